// file: src/adop_pkg.sv
package adop_pkg;

	// Data path widths
	localparam int WORD_W = 14;
	localparam int PIPE_DEPTH = 7;
	localparam int ADDR_W = 12;
	localparam int CNT_W = 16;

	// Register byte offsets
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;
	localparam logic [11:0] COUNT_OFS = 12'h008;

	// Control register field positions
	localparam int CTRL_OUT_DIS_BIT = 0;
	localparam int CTRL_PWR_DOWN_BIT = 1;
	localparam int CTRL_NOISE_BIT = 2;
	localparam int CTRL_SCRAMBLE_BIT = 3;
	localparam int CTRL_GAIN_BIT = 4;
	localparam int CTRL_MODE_LSB = 5;

	// Status register field positions
	localparam int STATUS_FLAG_BIT = 14;

	// Values after reset
	localparam logic RST_OUT_DIS = 1'b0;
	localparam logic RST_PWR_DOWN = 1'b0;
	localparam logic RST_NOISE = 1'b0;
	localparam logic RST_SCRAMBLE = 1'b0;
	localparam logic RST_GAIN = 1'b0;

	// Format select levels: ground, one third, two thirds, full supply
	typedef enum logic [1:0]
	{
		ADOP_MODE_OB_NODCS = 2'h0,
		ADOP_MODE_OB_DCS = 2'h1,
		ADOP_MODE_TC_DCS_A = 2'h2,
		ADOP_MODE_TC_DCS_B = 2'h3
	} adop_mode_t;

	localparam adop_mode_t RST_MODE = ADOP_MODE_OB_NODCS;

	// Most significant bit flip that turns offset binary into two's complement
	localparam logic [13:0] TC_FLIP = 14'h2000;

endpackage

// file: src/adop_pipe_if.sv
// Hand-off between the output port and the conversion delay line
interface adop_pipe_if;
	logic advance;
	logic [13:0] in_word;
	logic in_flag;
	logic [13:0] out_word;
	logic out_flag;

	modport producer (output advance, output in_word, output in_flag, input out_word, input out_flag);
	modport consumer (input advance, input in_word, input in_flag, output out_word, output out_flag);
endinterface

// file: src/adop_delay_line.sv
// Conversion pipeline: each sample moves one stage per accepted encode rising edge
module adop_delay_line
(
	input wire logic clock_i,     // System clock
	input wire logic reset_n_i,   // Async reset, active low
	adop_pipe_if.consumer pipe    // Samples in, delayed samples out
);

	typedef struct packed
	{
		logic [adop_pkg::PIPE_DEPTH-1:0][adop_pkg::WORD_W-1:0] word;
		logic [adop_pkg::PIPE_DEPTH-1:0] flag;
	} adop_line_t;

	adop_line_t st;
	adop_line_t next_st;

	// Shift word and flag together so the flag stays with its sample
	always_comb
	begin
		next_st = st;
		if (pipe.advance)
		begin
			next_st.word[0] = pipe.in_word;
			next_st.flag[0] = pipe.in_flag;
			for (int i = 1; i < adop_pkg::PIPE_DEPTH; i++)
			begin
				next_st.word[i] = st.word[i-1];
				next_st.flag[i] = st.flag[i-1];
			end
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			st <= '0;
		else
			st <= next_st;
	end

	// Oldest stage feeds the output register
	assign pipe.out_word = st.word[adop_pkg::PIPE_DEPTH-1];
	assign pipe.out_flag = st.flag[adop_pkg::PIPE_DEPTH-1];

endmodule

// file: src/adop_output_port.sv
//Contract
// - A rising positive encode edge freezes the sample for that conversion.
// - Power-down low is normal; high stops the core and floats outputs.
// - Dither-enable high turns internal dither on; low turns it off.
// - Each result is a 14-line word, line 13 the most significant.
// - Negative strobe toggles per sample; capture on its falling edge.
// - Positive strobe is the inverse; capture may use its rising edge.
// - Range flag goes high when the sample over- or underflowed.
// - Output-enable low drives the digital output lines.
// - Output-enable high puts the digital output lines in high impedance.
// - Format at ground: offset binary, duty-cycle stabilizer off.
// - Format at one third supply: offset binary, stabilizer on.
// - Format at two thirds or full supply: two's complement, stabilizer on.
// - Scramble high: bits 1..13 XORed with bit 0; bit 0 unchanged.
// - Scramble low sends unmodified words.
// - Gain low: unity gain, 2.25 V span; high: gain 1.5, 1.5 V span.
// - A sample appears at the outputs seven encode cycles after sampling.
module adop_output_port
(
	input wire logic clock_i,                 // System clock, 200 MHz
	input wire logic reset_n_i,               // Async reset, active low
	input wire logic sample_clock_pos_i,      // Encode input, positive leg
	input wire logic sample_clock_neg_i,      // Encode input, negative leg
	input wire logic [13:0] conv_word_i,      // Quantized core result, offset binary
	input wire logic conv_over_i,             // Core over/underflow indication
	input wire logic psel_i,                  // APB select
	input wire logic penable_i,               // APB access phase
	input wire logic pwrite_i,                // APB direction, high for write
	input wire logic [11:0] paddr_i,          // APB byte address
	input wire logic [31:0] pwdata_i,         // APB write data
	output logic [31:0] prdata_o,             // APB read data
	output logic pready_o,                    // APB ready
	output logic pslverr_o,                   // APB error, unmapped address
	output logic [13:0] sample_word_lines_o,  // Parallel sample word
	output logic sample_word_oe_o,            // Drive enable of word lines
	output logic range_exceeded_flag_o,       // Over/under range flag
	output logic range_flag_oe_o,             // Drive enable of range flag
	output logic data_strobe_neg_o,           // Data valid strobe
	output logic data_strobe_pos_o,           // Inverted data valid strobe
	output logic data_strobe_oe_o,            // Drive enable of both strobes
	output logic analog_power_down_o,         // Analog section powered off
	output logic noise_inject_select_o,       // Internal dither enable
	output logic input_gain_select_o,         // Front-end gain 1.5 when high
	output logic duty_stabilizer_en_o         // Clock duty-cycle stabilizer on
);

	typedef struct packed
	{
		logic pos_meta;
		logic pos_sync;
		logic neg_meta;
		logic neg_sync;
		logic [13:0] word_meta;
		logic [13:0] word_sync;
		logic over_meta;
		logic over_sync;
		logic enc_level;
		logic out_dis;
		logic power_down;
		logic noise;
		logic scramble;
		logic gain;
		adop_pkg::adop_mode_t mode;
		logic [13:0] out_word;
		logic out_flag;
		logic strobe_neg;
		logic strobe_pos;
		logic drive;
		logic dcs;
		logic [adop_pkg::CNT_W-1:0] count;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
	} adop_state_t;

	adop_state_t st;
	adop_state_t next_st;
	adop_pipe_if pipe ();

	logic enc_now;
	logic enc_rise;
	logic enc_fall;
	logic advance;
	logic twos;
	logic [13:0] fmt_word;
	logic apb_setup;
	logic apb_write;
	logic mapped;

	// Seven stages ahead of the output register
	adop_delay_line u_delay
	(
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.pipe(pipe)
	);

	// Delay line is fed only on accepted encode edges
	assign pipe.advance = advance;
	assign pipe.in_word = st.word_sync;
	assign pipe.in_flag = st.over_sync;

	always_comb
	begin
		next_st = st;

		// Two flops on every input from outside this clock
		next_st.pos_meta = sample_clock_pos_i;
		next_st.pos_sync = st.pos_meta;
		next_st.neg_meta = sample_clock_neg_i;
		next_st.neg_sync = st.neg_meta;
		next_st.word_meta = conv_word_i;
		next_st.word_sync = st.word_meta;
		next_st.over_meta = conv_over_i;
		next_st.over_sync = st.over_meta;

		// Differential compare; equal legs keep the old level to avoid chatter
		enc_now = st.enc_level;
		if (st.pos_sync && !st.neg_sync)
			enc_now = 1'b1;
		else if (!st.pos_sync && st.neg_sync)
			enc_now = 1'b0;
		next_st.enc_level = enc_now;
		enc_rise = enc_now && !st.enc_level;
		enc_fall = !enc_now && st.enc_level;

		// Core is off while powered down, so no sample is taken
		advance = enc_rise && !st.power_down;

		// Format then scramble, in that order
		twos = (st.mode == adop_pkg::ADOP_MODE_TC_DCS_A) || (st.mode == adop_pkg::ADOP_MODE_TC_DCS_B);
		fmt_word = twos ? (pipe.out_word ^ adop_pkg::TC_FLIP) : pipe.out_word;
		if (st.scramble)
			fmt_word[13:1] = fmt_word[13:1] ^ {13{fmt_word[0]}};

		// New word launched on encode rise with the strobe; capture waits for the following fall
		if (advance)
		begin
			next_st.out_word = fmt_word;
			next_st.out_flag = pipe.out_flag;
			next_st.strobe_neg = 1'b1;
			next_st.count = st.count + 16'h0001;
		end
		else if (enc_fall && !st.power_down)
			next_st.strobe_neg = 1'b0;
		next_st.strobe_pos = !next_st.strobe_neg;

		// APB: ready in the first access cycle, data registered with it
		apb_setup = psel_i && !penable_i;
		apb_write = psel_i && penable_i && st.ready && pwrite_i;
		mapped = (paddr_i == adop_pkg::CTRL_OFS) || (paddr_i == adop_pkg::STATUS_OFS) ||
			(paddr_i == adop_pkg::COUNT_OFS);
		next_st.ready = apb_setup;
		next_st.slverr = apb_setup && !mapped;
		next_st.rdata = 32'h0000_0000;
		if (apb_setup && !pwrite_i)
		begin
			unique case (paddr_i)
				adop_pkg::CTRL_OFS:
				begin
					next_st.rdata[adop_pkg::CTRL_OUT_DIS_BIT] = st.out_dis;
					next_st.rdata[adop_pkg::CTRL_PWR_DOWN_BIT] = st.power_down;
					next_st.rdata[adop_pkg::CTRL_NOISE_BIT] = st.noise;
					next_st.rdata[adop_pkg::CTRL_SCRAMBLE_BIT] = st.scramble;
					next_st.rdata[adop_pkg::CTRL_GAIN_BIT] = st.gain;
					next_st.rdata[adop_pkg::CTRL_MODE_LSB +: 2] = st.mode;
				end
				adop_pkg::STATUS_OFS:
				begin
					next_st.rdata[13:0] = st.out_word;
					next_st.rdata[adop_pkg::STATUS_FLAG_BIT] = st.out_flag;
				end
				adop_pkg::COUNT_OFS:
					next_st.rdata[adop_pkg::CNT_W-1:0] = st.count;
				default:
					next_st.rdata = 32'h0000_0000;
			endcase
		end
		if (apb_write && (paddr_i == adop_pkg::CTRL_OFS))
		begin
			next_st.out_dis = pwdata_i[adop_pkg::CTRL_OUT_DIS_BIT];
			next_st.power_down = pwdata_i[adop_pkg::CTRL_PWR_DOWN_BIT];
			next_st.noise = pwdata_i[adop_pkg::CTRL_NOISE_BIT];
			next_st.scramble = pwdata_i[adop_pkg::CTRL_SCRAMBLE_BIT];
			next_st.gain = pwdata_i[adop_pkg::CTRL_GAIN_BIT];
			next_st.mode = adop_pkg::adop_mode_t'(pwdata_i[adop_pkg::CTRL_MODE_LSB +: 2]);
		end

		// Drivers float when disabled or powered down
		next_st.drive = !next_st.out_dis && !next_st.power_down;
		next_st.dcs = next_st.mode != adop_pkg::ADOP_MODE_OB_NODCS;
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st <= '0;
			st.out_dis <= adop_pkg::RST_OUT_DIS;
			st.power_down <= adop_pkg::RST_PWR_DOWN;
			st.noise <= adop_pkg::RST_NOISE;
			st.scramble <= adop_pkg::RST_SCRAMBLE;
			st.gain <= adop_pkg::RST_GAIN;
			st.mode <= adop_pkg::RST_MODE;
			st.strobe_pos <= 1'b1;
			st.drive <= !adop_pkg::RST_OUT_DIS && !adop_pkg::RST_PWR_DOWN;
		end
		else
			st <= next_st;
	end

	// Every output straight from the state register
	assign prdata_o = st.rdata;
	assign pready_o = st.ready;
	assign pslverr_o = st.slverr;
	assign sample_word_lines_o = st.out_word;
	assign sample_word_oe_o = st.drive;
	assign range_exceeded_flag_o = st.out_flag;
	assign range_flag_oe_o = st.drive;
	assign data_strobe_neg_o = st.strobe_neg;
	assign data_strobe_pos_o = st.strobe_pos;
	assign data_strobe_oe_o = st.drive;
	assign analog_power_down_o = st.power_down;
	assign noise_inject_select_o = st.noise;
	assign input_gain_select_o = st.gain;
	assign duty_stabilizer_en_o = st.dcs;

endmodule

// file: verif/adop_capture_model.sv
// Receiver beside the port: latches what the pins show at the strobe
module adop_capture_model
(
	input wire logic strobe_i,        // Data valid strobe on the wire
	input wire logic [13:0] lines_i,  // Word lines on the wire
	input wire logic flag_i,          // Range flag on the wire
	input wire logic descramble_i,    // Undo output scrambling
	output logic [13:0] word_o,       // Captured, recovered word
	output logic flag_o               // Captured range flag
);
	timeunit 1ns;
	timeprecision 1ps;
	// Falling strobe edge, the point where the data is settled
	always @(negedge strobe_i)
	begin
		word_o <= descramble_i ? lines_i ^ {{13{lines_i[0]}}, 1'b0} : lines_i;
		flag_o <= flag_i;
	end
endmodule

// file: verif/adop_output_port_assertions.sv
module adop_output_port_assertions
(
	input wire logic clock_i, reset_n_i, sample_clock_pos_i, psel_i, penable_i, pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i, prdata_o,
	input wire logic pready_o, pslverr_o, range_exceeded_flag_o, range_flag_oe_o, data_strobe_neg_o,
	input wire logic [13:0] sample_word_lines_o,
	input wire logic sample_word_oe_o, data_strobe_pos_o, data_strobe_oe_o, analog_power_down_o,
	input wire logic noise_inject_select_o, input_gain_select_o, duty_stabilizer_en_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	logic ctrl_wr;
	logic [31:0] last_ctrl;
	// Last control word written, so outputs are judged against software intent
	assign ctrl_wr = psel_i && penable_i && pwrite_i && pready_o && paddr_i == adop_pkg::CTRL_OFS;
	always_ff @(posedge clock_i or negedge reset_n_i)
		if (!reset_n_i)
			last_ctrl <= 32'h0;
		else if (ctrl_wr)
			last_ctrl <= pwdata_i;
	// Encode edges seen while the core runs; the sync chain costs three clocks
	sequence s_enc_rise;
		$rose(sample_clock_pos_i) && !analog_power_down_o;
	endsequence
	sequence s_enc_fall;
		$fell(sample_clock_pos_i) && !analog_power_down_o;
	endsequence
	strobe_pair_a: assert property (data_strobe_pos_o == !data_strobe_neg_o) else $error("strobe legs equal");
	drive_same_a: assert property (range_flag_oe_o == sample_word_oe_o && data_strobe_oe_o == sample_word_oe_o)
		else $error("drive enables differ");
	power_float_a: assert property (analog_power_down_o && $past(analog_power_down_o) |-> !sample_word_oe_o)
		else $error("outputs driven in power down");
	word_hold_a: assert property (!$rose(data_strobe_neg_o) |-> $stable(sample_word_lines_o) &&
		$stable(range_exceeded_flag_o)) else $error("word moved without strobe");
	enc_rise_a: assert property (s_enc_rise |-> ##[2:3] data_strobe_neg_o) else $error("no strobe rise");
	enc_fall_a: assert property (s_enc_fall |-> ##[2:3] !data_strobe_neg_o) else $error("no strobe fall");
	ctrl_dither_a: assert property (ctrl_wr |=> ##1 noise_inject_select_o == last_ctrl[adop_pkg::CTRL_NOISE_BIT])
		else $error("dither select wrong");
	ctrl_gain_a: assert property (ctrl_wr |=> ##1 input_gain_select_o == last_ctrl[adop_pkg::CTRL_GAIN_BIT])
		else $error("gain select wrong");
	ctrl_dcs_a: assert property (ctrl_wr |=> ##1 duty_stabilizer_en_o == (last_ctrl[adop_pkg::CTRL_MODE_LSB +: 2] != 2'h0))
		else $error("stabilizer enable wrong");
	unmapped_err_a: assert property (psel_i && !penable_i && paddr_i > adop_pkg::COUNT_OFS |=>
		pready_o && pslverr_o && prdata_o == 32'h0) else $error("unmapped access not refused");
endmodule

bind adop_output_port adop_output_port_assertions chk_u (.*);

// file: verif/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 0, reset_n_i = 0, sample_clock_pos_i = 0, conv_over_i = 0, psel_i = 0, penable_i = 0;
	logic pwrite_i = 0, pready_o, pslverr_o, sample_word_oe_o, range_exceeded_flag_o, range_flag_oe_o;
	logic data_strobe_neg_o, data_strobe_pos_o, data_strobe_oe_o, analog_power_down_o, noise_inject_select_o;
	logic input_gain_select_o, duty_stabilizer_en_o, err, cap_f, s;
	logic [13:0] conv_word_i = 14'h0, sample_word_lines_o, cap_w, fmt;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic [14:0] e, last;
	logic [14:0] hist[$];
	logic [6:0] ctrl = 7'h0;
	int n_errors = 0, compares = 0, cycles = 0, valid = 0;
	wire logic sample_clock_neg_i = !sample_clock_pos_i;
	// Released pins show the inverse of their last value, never a kind copy
	wire logic [13:0] w_lines = sample_word_oe_o ? sample_word_lines_o : ~sample_word_lines_o;
	wire logic w_flag = range_flag_oe_o ? range_exceeded_flag_o : !range_exceeded_flag_o;
	wire logic w_strobe = data_strobe_oe_o ? data_strobe_neg_o : !data_strobe_neg_o;
	adop_output_port dut_u (.*);
	adop_capture_model cap_u (.strobe_i(w_strobe), .lines_i(w_lines), .flag_i(w_flag), .descramble_i(ctrl[3]),
		.word_o(cap_w), .flag_o(cap_f));
	initial forever #2.5 clock_i = ~clock_i;
	task automatic wrap_up();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x)
		begin
			n_errors++;
			$display("unexpected at %0t: expected %h got %h", $time, x, g);
		end
	endtask
	// One transfer; an edge is left free after it so psel never toggles twice at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		// Request stands until the edge that samples ready high; data taken there
		do
			@(posedge clock_i);
		while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask
	// One 160 ns encode period; the core result changes well away from the rise
	task automatic enc(input bit live);
		conv_word_i <= 14'($urandom);
		conv_over_i <= ($urandom % 6) == 0;
		repeat (8) @(posedge clock_i);
		// Word from the previous rise must still stand when the encode pin rises
		if (live && valid >= 8)
			chk(32'(last), 32'({w_flag, w_lines}));
		sample_clock_pos_i <= 1'b1;
		if (live)
		begin
			hist.push_back({conv_over_i, conv_word_i});
			valid++;
		end
		repeat (16) @(posedge clock_i);
		sample_clock_pos_i <= 1'b0;
		repeat (8) @(posedge clock_i);
		if (live && valid >= 8)
		begin
			e = hist[hist.size() - 8];
			fmt = e[13:0] ^ (ctrl[6:5] >= 2'h2 ? adop_pkg::TC_FLIP : 14'h0);
			last = {e[14], ctrl[3] ? fmt ^ {{13{fmt[0]}}, 1'b0} : fmt};
			chk(32'(fmt), 32'(cap_w));
			chk(32'(last), 32'({range_exceeded_flag_o, sample_word_lines_o}));
			chk(32'(e[14]), 32'(cap_f));
		end
	endtask
	// Hang guard
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	initial
	begin
		void'($urandom(32'h1026a1c4));
		repeat (4) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		chk(32'h6, 32'({data_strobe_pos_o, sample_word_oe_o, duty_stabilizer_en_o}));
		apb(1'b0, adop_pkg::CTRL_OFS, 32'h0);
		chk(32'h0, rd);
		apb(1'b0, 12'h00c, 32'h0);
		chk(32'h1, 32'(err));
		// Every format and scramble pairing, gain and dither at random
		for (int m = 0; m < 8; m++)
		begin
			ctrl = {m[2:1], 1'($urandom), m[0], 1'($urandom), 2'h0};
			apb(1'b1, adop_pkg::CTRL_OFS, 32'(ctrl));
			valid = 0;
			repeat (3) @(posedge clock_i);
			chk(32'({ctrl[6:5] != 2'h0, ctrl[2], ctrl[4]}),
				32'({duty_stabilizer_en_o, noise_inject_select_o, input_gain_select_o}));
			repeat (10) enc(1'b1);
			apb(1'b0, adop_pkg::STATUS_OFS, 32'h0);
			chk(32'(last), rd);
		end
		// Floated outputs while conversion keeps running
		ctrl = 7'h0;
		valid = 0;
		apb(1'b1, adop_pkg::CTRL_OFS, 32'h1);
		repeat (3) @(posedge clock_i);
		chk(32'h0, 32'(sample_word_oe_o));
		enc(1'b1);
		apb(1'b1, adop_pkg::CTRL_OFS, 32'h0);
		repeat (3) @(posedge clock_i);
		chk(32'h1, 32'(sample_word_oe_o));
		// Power down freezes the strobes; the pipeline resumes with old stages
		apb(1'b1, adop_pkg::CTRL_OFS, 32'h2);
		repeat (3) @(posedge clock_i);
		chk(32'h2, 32'({analog_power_down_o, sample_word_oe_o}));
		s = data_strobe_neg_o;
		enc(1'b0);
		chk(32'(s), 32'(data_strobe_neg_o));
		apb(1'b1, adop_pkg::CTRL_OFS, 32'h0);
		valid = 0;
		repeat (9) enc(1'b1);
		wrap_up();
	end
endmodule
